// File: sso_cmp.sv
// running-output source: speed compare or torque-limit flag
// assumes speed and level in r/min, same clock as the top
`timescale 1ns/1ps
module sso_cmp (
    sso_eval_if.cmp ev
);
    import sso_pkg::*;

    function automatic logic at_or_above(input sso_data_t spd, input sso_data_t lvl);
        at_or_above = (spd >= lvl);
    endfunction : at_or_above

    assign ev.result = ev.sel_torque ? ev.torque_lim : at_or_above(ev.speed, ev.level);
endmodule : sso_cmp

// File: sso_defines.svh
// register offsets, field positions, reset values and timing counts
// for the servo status output block; definitions only
`ifndef SSO_DEFINES_SVH
`define SSO_DEFINES_SVH

`define SSO_OFF_MEMSW 4'h0
`define SSO_OFF_ZSL 4'h1
`define SSO_OFF_MON 4'h2
`define SSO_OFF_INT_STAT 4'h3
`define SSO_OFF_INT_MASK 4'h4
`define SSO_OFF_SPEED 4'h5

`define SSO_SEL_BIT 14
`define SSO_ABS_BIT 3

`define SSO_MON_READY_BIT 0
`define SSO_MON_ALARM_BIT 1
`define SSO_MON_POWER_BIT 2
`define SSO_MON_TLIM_BIT 3
`define SSO_MON_RUN_BIT 4

`define SSO_IRQ_RUN_ON 0
`define SSO_IRQ_RUN_OFF 1
`define SSO_IRQ_RDY_ON 2
`define SSO_IRQ_RDY_OFF 3
`define SSO_IRQ_ALARM 4
`define SSO_IRQ_W 5

`define SSO_MEMSW_RST 16'h0000
`define SSO_ZSL_RST 16'h0014
`define SSO_ZSL_MIN 16'h0001
`define SSO_MAX_SPEED 16'h1388

`define SSO_CLK_NS 25
`define SSO_CYCLE_NS 1000
`define SSO_CYCLE_CLKS (`SSO_CYCLE_NS / `SSO_CLK_NS)

`endif

// File: sso_eval_if.sv
// carrier between the top and the speed comparator
// assumes one clock domain; all members are plain levels
`timescale 1ns/1ps
interface sso_eval_if;
    import sso_pkg::*;
    sso_data_t speed;
    sso_data_t level;
    logic sel_torque;
    logic torque_lim;
    logic result;

    modport top (output speed, output level, output sel_torque, output torque_lim, input result);
    modport cmp (input speed, input level, input sel_torque, input torque_lim, output result);
endinterface : sso_eval_if

// File: sso_host_model.sv
// host controller model: reads both contacts as interlock inputs
// assumes a closed contact shows the pos terminal level equal to return
`timescale 1ns/1ps
module sso_host_model (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic running_out_pos,
    input wire logic running_out_neg,
    input wire logic servo_ready_n,
    output logic motor_running,
    output logic drive_ready
);
    // registered like an input card, so one cycle behind the pins
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            motor_running <= 1'b0;
            drive_ready <= 1'b0;
        end else begin
            motor_running <= (running_out_pos == running_out_neg);
            drive_ready <= !servo_ready_n;
        end
    end
endmodule : sso_host_model

// File: sso_pkg.sv
// types shared by the servo status output modules
// assumes sso_defines.svh is on the include path
package sso_pkg;
    typedef logic [3:0] sso_addr_t;
    typedef logic [15:0] sso_data_t;

    typedef enum logic [3:0] {
        SSO_ST_OFF = 4'h1,
        SSO_ST_ALARM = 4'h2,
        SSO_ST_ENC = 4'h4,
        SSO_ST_READY = 4'h8
    } sso_ready_e;
endpackage : sso_pkg

// File: sso_sync.sv
// two-flop synchroniser for a group of pin levels
// assumes inputs are asynchronous levels, not pulses
`timescale 1ns/1ps
module sso_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : sso_sync

// File: sso_top.sv
// servo status outputs: running/torque-limit contact and servo-ready
// assumes speed, torque-limit and alarm inputs come from logic on sys_clk;
// power, encoder sense/ready and control-power levels come from pins
//
// How it works
// - running selected: contact closes when speed is at or above zero-speed level
// - running selected: contact opens when speed is below zero-speed level
// - switch bit E at 0 routes running comparison to the contact pair
// - switch bit E at 1 routes torque-limit indication to the pair instead
// - monitor bit 4 and display bit follow the contact state together
// - active contact is closed, positive terminal low; inactive is open, high
// - servo-ready only with main power on and no alarm
// - absolute encoder also needs sense input high and encoder ready
// - alarm state clears when control power turns on or off, unless a new alarm arrives in that same clock
// - ready drives low when active, high when not ready
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "sso_defines.svh"
module sso_top #(
    parameter logic [15:0] MAX_SPEED = `SSO_MAX_SPEED,
    parameter int CYCLE_CLKS = `SSO_CYCLE_CLKS
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire sso_pkg::sso_addr_t reg_addr,
    input wire sso_pkg::sso_data_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output sso_pkg::sso_data_t reg_rdata,
    input wire sso_pkg::sso_data_t motor_speed,
    input wire logic torque_limit_active,
    input wire logic servo_alarm_in,
    input wire logic main_power_on,
    input wire logic encoder_sense_in,
    input wire logic encoder_ready,
    input wire logic control_power_ok,
    output logic running_out_pos,
    output logic running_out_neg,
    output logic status_display_bit,
    output logic servo_ready_n,
    output logic irq
);
    import sso_pkg::*;

    localparam logic [15:0] CYCLE_LAST = 16'(CYCLE_CLKS - 1);

    sso_eval_if ev ();

    // pin levels
    logic [3:0] pins_s;
    logic power_s;
    logic sense_s;
    logic enc_rdy_s;
    logic cpwr_s;

    // control cycle divider
    logic [15:0] div_q;
    logic tick;

    // registers
    sso_data_t memsw_q;
    sso_data_t zsl_q;
    logic [`SSO_IRQ_W-1:0] int_stat_q;
    logic [`SSO_IRQ_W-1:0] int_mask_q;
    logic [`SSO_IRQ_W-1:0] events;
    sso_data_t speed_q;

    // status state
    logic alarm_q;
    logic cpwr_prev_q;
    logic [1:0] cpwr_fill_q;
    logic cpwr_armed;
    logic cpwr_edge;
    logic running_q;
    logic running_d;
    sso_ready_e rdy_q;
    sso_ready_e rdy_d;
    sso_ready_e rdy_pick;
    logic enc_ok;
    logic ready_now;
    logic ready_next;

    logic wr_memsw;
    logic wr_zsl;
    logic wr_stat;
    logic wr_mask;

    function automatic sso_data_t clamp_level(input sso_data_t v, input sso_data_t vmax);
        if (v < `SSO_ZSL_MIN) begin
            clamp_level = `SSO_ZSL_MIN;
        end else if (v > vmax) begin
            clamp_level = vmax;
        end else begin
            clamp_level = v;
        end
    endfunction : clamp_level

    function automatic logic hit(input sso_addr_t a, input sso_addr_t off);
        hit = (a == off);
    endfunction : hit

    sso_sync #(
        .W(4)
    ) u_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .d({control_power_ok, encoder_ready, encoder_sense_in, main_power_on}),
        .q(pins_s)
    );

    assign power_s = pins_s[0];
    assign sense_s = pins_s[1];
    assign enc_rdy_s = pins_s[2];
    assign cpwr_s = pins_s[3];

    // one tick per control cycle
    // 16-bit count: CYCLE_CLKS may not exceed 65536
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            div_q <= 16'h0000;
        end else if (div_q == CYCLE_LAST) begin
            div_q <= 16'h0000;
        end else begin
            div_q <= div_q + 16'h0001;
        end
    end

    assign tick = (div_q == CYCLE_LAST);

    assign wr_memsw = reg_wr && hit(reg_addr, `SSO_OFF_MEMSW);
    assign wr_zsl = reg_wr && hit(reg_addr, `SSO_OFF_ZSL);
    assign wr_stat = reg_wr && hit(reg_addr, `SSO_OFF_INT_STAT);
    assign wr_mask = reg_wr && hit(reg_addr, `SSO_OFF_INT_MASK);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            memsw_q <= `SSO_MEMSW_RST;
        end else if (wr_memsw) begin
            memsw_q <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            zsl_q <= `SSO_ZSL_RST;
        end else if (wr_zsl) begin
            zsl_q <= clamp_level(reg_wdata, MAX_SPEED);
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            int_mask_q <= '0;
        end else if (wr_mask) begin
            int_mask_q <= reg_wdata[`SSO_IRQ_W-1:0];
        end
    end

    // speed seen at the last evaluation, for software
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            speed_q <= 16'h0000;
        end else if (tick) begin
            speed_q <= motor_speed;
        end
    end

    assign ev.speed = motor_speed;
    assign ev.level = zsl_q;
    assign ev.sel_torque = memsw_q[`SSO_SEL_BIT];
    assign ev.torque_lim = torque_limit_active;

    sso_cmp u_cmp (
        .ev(ev.cmp)
    );

    // source chosen inside the comparator, sampled per cycle
    assign running_d = tick ? ev.result : running_q;

    // running state moves only on the tick
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            running_q <= 1'b0;
        end else begin
            running_q <= running_d;
        end
    end

    // edge detect armed only once the synchroniser has filled; its reset
    // zeros would otherwise look like a power edge and could wipe an
    // alarm raised in the first cycles after reset
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cpwr_fill_q <= 2'h0;
        end else if (cpwr_fill_q != 2'h3) begin
            cpwr_fill_q <= cpwr_fill_q + 2'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cpwr_prev_q <= 1'b0;
        end else begin
            cpwr_prev_q <= cpwr_s;
        end
    end

    assign cpwr_armed = (cpwr_fill_q == 2'h3);
    assign cpwr_edge = cpwr_armed && (cpwr_s != cpwr_prev_q);

    // alarm cleared on either control-power edge; a new alarm wins
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            alarm_q <= 1'b0;
        end else if (servo_alarm_in) begin
            alarm_q <= 1'b1;
        end else if (cpwr_edge) begin
            alarm_q <= 1'b0;
        end
    end

    assign enc_ok = !memsw_q[`SSO_ABS_BIT] || (sense_s && enc_rdy_s);

    always_comb begin
        if (!power_s) begin
            rdy_pick = SSO_ST_OFF;
        end else if (alarm_q) begin
            rdy_pick = SSO_ST_ALARM;
        end else if (!enc_ok) begin
            rdy_pick = SSO_ST_ENC;
        end else begin
            rdy_pick = SSO_ST_READY;
        end
    end

    // alarm state is left once the alarm is gone or main power drops, never skipped past
    always_comb begin
        rdy_d = rdy_q;
        if (tick) begin
            unique case (rdy_q)
                SSO_ST_OFF: rdy_d = rdy_pick;
                SSO_ST_ALARM: begin
                    if (!alarm_q || !power_s) begin
                        rdy_d = rdy_pick;
                    end
                end
                SSO_ST_ENC: rdy_d = rdy_pick;
                SSO_ST_READY: rdy_d = rdy_pick;
                default: rdy_d = SSO_ST_OFF;
            endcase
        end
    end

    // readiness moves only on the tick
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rdy_q <= SSO_ST_OFF;
        end else begin
            rdy_q <= rdy_d;
        end
    end

    assign ready_now = (rdy_q == SSO_ST_READY);
    assign ready_next = (rdy_d == SSO_ST_READY);

    // pins and display bit share one update
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            running_out_pos <= 1'b1;
            running_out_neg <= 1'b0;
            status_display_bit <= 1'b0;
        end else begin
            running_out_pos <= !running_d;
            running_out_neg <= 1'b0;
            status_display_bit <= running_d;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            servo_ready_n <= 1'b1;
        end else begin
            servo_ready_n <= !ready_next;
        end
    end

    // edges taken from the next state, so each flag lands with its pin
    always_comb begin
        events = '0;
        events[`SSO_IRQ_RUN_ON] = running_d && !running_q;
        events[`SSO_IRQ_RUN_OFF] = !running_d && running_q;
        events[`SSO_IRQ_RDY_ON] = ready_next && !ready_now;
        events[`SSO_IRQ_RDY_OFF] = !ready_next && ready_now;
        events[`SSO_IRQ_ALARM] = servo_alarm_in && !alarm_q;
    end

    // sticky; an event in the clearing cycle survives
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            int_stat_q <= '0;
        end else if (wr_stat) begin
            int_stat_q <= (int_stat_q & ~reg_wdata[`SSO_IRQ_W-1:0]) | events;
        end else begin
            int_stat_q <= int_stat_q | events;
        end
    end

    // level output; high until software clears or masks every source
    assign irq = |(int_stat_q & int_mask_q);

    // read data valid only in the cycle after the strobe
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= 16'h0000;
            unique case (reg_addr)
                `SSO_OFF_MEMSW: reg_rdata <= memsw_q;
                `SSO_OFF_ZSL: reg_rdata <= zsl_q;
                // monitor bit 4 mirrors the contact
                `SSO_OFF_MON: begin
                    reg_rdata[`SSO_MON_READY_BIT] <= ready_now;
                    reg_rdata[`SSO_MON_ALARM_BIT] <= alarm_q;
                    reg_rdata[`SSO_MON_POWER_BIT] <= power_s;
                    reg_rdata[`SSO_MON_TLIM_BIT] <= torque_limit_active;
                    reg_rdata[`SSO_MON_RUN_BIT] <= running_q;
                end
                `SSO_OFF_INT_STAT: reg_rdata[`SSO_IRQ_W-1:0] <= int_stat_q;
                `SSO_OFF_INT_MASK: reg_rdata[`SSO_IRQ_W-1:0] <= int_mask_q;
                `SSO_OFF_SPEED: reg_rdata <= speed_q;
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule : sso_top

// File: sso_top_sva.sv
// concurrent checks on the status pins of sso_top
// assumes a control cycle of 4 clocks in simulation; bound below
`timescale 1ns/1ps
module sso_top_sva #(
    parameter logic [15:0] MAX_SPEED = 16'h1388,
    parameter int CYCLE_CLKS = 4
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire sso_pkg::sso_data_t motor_speed,
    input wire logic torque_limit_active,
    input wire logic servo_alarm_in,
    input wire logic main_power_on,
    input wire logic running_out_pos,
    input wire logic running_out_neg,
    input wire logic status_display_bit,
    input wire logic servo_ready_n,
    input wire logic irq
);
    import sso_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    a_return_held_low: assert property (running_out_neg == 1'b0)
        else $error("return terminal not low");
    a_display_follows: assert property (status_display_bit == !running_out_pos)
        else $error("display bit differs from contact");
    a_run_when_fast: assert property ((motor_speed >= MAX_SPEED && torque_limit_active)[*6] |=> !running_out_pos)
        else $error("contact open at full speed");
    a_idle_when_still: assert property ((motor_speed == 16'h0000 && !torque_limit_active)[*6] |=> running_out_pos)
        else $error("contact closed at standstill");
    a_run_holds_cycle: assert property ($changed(running_out_pos) |=> $stable(running_out_pos)[*3])
        else $error("contact changed inside a control cycle");
    a_unpowered_idle: assert property ((!main_power_on)[*7] |=> servo_ready_n)
        else $error("ready without main power");
    a_alarm_drops_ready: assert property (servo_alarm_in |-> ##[1:12] servo_ready_n)
        else $error("ready kept after alarm");
    a_ready_needs_power: assert property ($fell(servo_ready_n) |-> $past(main_power_on, 3))
        else $error("ready rose with power off");
    a_reset_idle: assert property ($rose(resetn) |-> running_out_pos && servo_ready_n && !irq)
        else $error("outputs not idle after reset");
endmodule : sso_top_sva

bind sso_top sso_top_sva #(.MAX_SPEED(MAX_SPEED), .CYCLE_CLKS(CYCLE_CLKS)) u_sso_top_sva (
    .sys_clk(sys_clk), .resetn(resetn), .motor_speed(motor_speed), .torque_limit_active(torque_limit_active),
    .servo_alarm_in(servo_alarm_in), .main_power_on(main_power_on), .running_out_pos(running_out_pos),
    .running_out_neg(running_out_neg), .status_display_bit(status_display_bit), .servo_ready_n(servo_ready_n),
    .irq(irq));

// File: tb.sv
// self-checking bench for sso_top with the host model
// assumes a control cycle of 4 clocks; pins settle within 8 clocks
`timescale 1ns/1ps
`include "sso_defines.svh"
module tb;
    import sso_pkg::*;
    logic sys_clk, resetn, reg_wr, reg_rd, irq;
    sso_addr_t reg_addr;
    sso_data_t reg_wdata, reg_rdata, motor_speed;
    logic torque_limit_active, servo_alarm_in, main_power_on, encoder_sense_in, encoder_ready, control_power_ok;
    logic running_out_pos, running_out_neg, status_display_bit, servo_ready_n, motor_running, drive_ready;
    int mismatches, checks_done, cycles;

    sso_top #(.CYCLE_CLKS(4)) u_sso_top (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .motor_speed(motor_speed),
        .torque_limit_active(torque_limit_active), .servo_alarm_in(servo_alarm_in), .main_power_on(main_power_on),
        .encoder_sense_in(encoder_sense_in), .encoder_ready(encoder_ready), .control_power_ok(control_power_ok),
        .running_out_pos(running_out_pos), .running_out_neg(running_out_neg),
        .status_display_bit(status_display_bit), .servo_ready_n(servo_ready_n), .irq(irq));
    sso_host_model u_sso_host_model (.sys_clk(sys_clk), .resetn(resetn), .running_out_pos(running_out_pos),
        .running_out_neg(running_out_neg), .servo_ready_n(servo_ready_n), .motor_running(motor_running),
        .drive_ready(drive_ready));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    // a hang ends the run as a mismatch
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            conclude();
        end
    end

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic wr(input sso_addr_t a, input sso_data_t d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input string name, input sso_addr_t a, input sso_data_t exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        check(name, exp, reg_rdata);
    endtask : rd

    task automatic run_is(input sso_data_t s, input logic act);
        @(posedge sys_clk);
        motor_speed <= s;
        repeat (8) @(posedge sys_clk);
        #1;
        check("running_out_pos", !act, running_out_pos);
        check("status_display_bit", act, status_display_bit);
        check("running_out_neg", 1'b0, running_out_neg);
        check("motor_running", act, motor_running);
    endtask : run_is

    task automatic ready_is(input logic act);
        repeat (8) @(posedge sys_clk);
        #1;
        check("servo_ready_n", !act, servo_ready_n);
        check("drive_ready", act, drive_ready);
    endtask : ready_is

    task automatic t_reset;
        check("pos_rst", 1'b1, running_out_pos);
        check("rdy_rst", 1'b1, servo_ready_n);
        check("irq_rst", 1'b0, irq);
        rd("zsl_rst", `SSO_OFF_ZSL, `SSO_ZSL_RST);
        rd("memsw_rst", `SSO_OFF_MEMSW, 16'h0000);
        rd("unmapped", 4'hf, 16'h0000);
    endtask : t_reset

    task automatic t_run;
        run_is(16'h0014, 1'b1);
        rd("mon_run", `SSO_OFF_MON, 16'h0010);
        run_is(16'h0013, 1'b0);
        wr(`SSO_OFF_ZSL, 16'h0000);
        rd("zsl_low", `SSO_OFF_ZSL, 16'h0001);
        wr(`SSO_OFF_ZSL, 16'hffff);
        rd("zsl_high", `SSO_OFF_ZSL, 16'h1388);
        wr(`SSO_OFF_ZSL, 16'h0001);
        run_is(16'h0001, 1'b1);
        run_is(16'h0000, 1'b0);
        wr(`SSO_OFF_ZSL, 16'h0014);
    endtask : t_run

    task automatic t_select;
        wr(`SSO_OFF_MEMSW, 16'h4000);
        torque_limit_active <= 1'b1;
        run_is(16'h0000, 1'b1);
        torque_limit_active <= 1'b0;
        run_is(16'h1388, 1'b0);
        torque_limit_active <= 1'b1;
        run_is(16'h1388, 1'b1);
        wr(`SSO_OFF_MEMSW, 16'h0000);
        run_is(16'h0000, 1'b0);
        torque_limit_active <= 1'b0;
    endtask : t_select

    task automatic t_ready;
        ready_is(1'b0);
        main_power_on <= 1'b1;
        ready_is(1'b1);
        servo_alarm_in <= 1'b1;
        @(posedge sys_clk);
        servo_alarm_in <= 1'b0;
        ready_is(1'b0);
        rd("mon_alarm", `SSO_OFF_MON, 16'h0006);
        control_power_ok <= 1'b0;
        ready_is(1'b1);
        wr(`SSO_OFF_MEMSW, 16'h0008);
        ready_is(1'b0);
        encoder_sense_in <= 1'b1;
        ready_is(1'b0);
        encoder_ready <= 1'b1;
        ready_is(1'b1);
        encoder_sense_in <= 1'b0;
        ready_is(1'b0);
        wr(`SSO_OFF_MEMSW, 16'h0000);
        ready_is(1'b1);
        servo_alarm_in <= 1'b1;
        @(posedge sys_clk);
        servo_alarm_in <= 1'b0;
        ready_is(1'b0);
        control_power_ok <= 1'b1;
        ready_is(1'b1);
    endtask : t_ready

    task automatic t_irq;
        wr(`SSO_OFF_INT_STAT, 16'h001f);
        wr(`SSO_OFF_INT_MASK, 16'h0001);
        #1;
        check("irq_clear", 1'b0, irq);
        rd("int_mask", `SSO_OFF_INT_MASK, 16'h0001);
        run_is(16'h0064, 1'b1);
        check("irq_set", 1'b1, irq);
        rd("speed", `SSO_OFF_SPEED, 16'h0064);
        wr(`SSO_OFF_INT_STAT, 16'h0001);
        #1;
        check("irq_w1c", 1'b0, irq);
        wr(`SSO_OFF_INT_MASK, 16'h0000);
        run_is(16'h0000, 1'b0);
        check("irq_masked", 1'b0, irq);
        rd("int_stat", `SSO_OFF_INT_STAT, 16'h0002);
    endtask : t_irq

    initial begin
        resetn = 1'b0;
        cycles = 0;
        mismatches = 0;
        checks_done = 0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        motor_speed = 16'h0000;
        torque_limit_active = 1'b0;
        servo_alarm_in = 1'b0;
        main_power_on = 1'b0;
        encoder_sense_in = 1'b0;
        encoder_ready = 1'b0;
        control_power_ok = 1'b1;
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        #1;
        t_reset();
        t_run();
        t_select();
        t_ready();
        t_irq();
        conclude();
    end
endmodule : tb
